// file: hdl/fra_core.sv
`timescale 1ns/100ps
`default_nettype none
module fra_core (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic op_valid_in,
  input wire fra_pkg::fra_op_t op_in,
  input wire logic [6:0] file_addr_in,
  input wire logic dest_sel_in,
  input wire logic [6:0] counter_high_latch_in,
  output logic ready_out,
  output logic [14:0] program_counter_out,
  output logic [14:0] stack_top_out,
  output logic push_out,
  output logic skip_out,
  output logic [7:0] accumulator_out,
  output logic null_result_flag_out
);
  typedef struct packed {
    fra_pkg::fra_state_t st;
    fra_pkg::fra_op_t op;
    logic [6:0] addr;
    logic dest;
    logic ready;
    logic [14:0] pc;
    logic [14:0] stack_top;
    logic push;
    logic skip;
    logic [7:0] acc;
    logic zf;
  } fra_core_state_t;

  fra_core_state_t cur_r;
  fra_core_state_t cur_nxt;
  logic [7:0] res;
  logic res_zero;
  logic routed;

  fra_mem_if mif ();

  fra_file_mem u_mem (
    .mclk_in(mclk_in),
    .mif(mif.mem)
  );

  always_comb begin
    case (cur_r.op)
      fra_pkg::FRA_OP_INVERT_FILE: res = ~mif.rdata;
      fra_pkg::FRA_OP_REDUCE_FILE,
      fra_pkg::FRA_OP_REDUCE_SKIP: res = mif.rdata - fra_pkg::FRA_ONE_BYTE;
      fra_pkg::FRA_OP_RAISE_SKIP: res = mif.rdata + fra_pkg::FRA_ONE_BYTE;
      default: res = fra_pkg::FRA_ZERO_BYTE;
    endcase
    res_zero = (res == fra_pkg::FRA_ZERO_BYTE);
    routed = (cur_r.op == fra_pkg::FRA_OP_INVERT_FILE) ||
             (cur_r.op == fra_pkg::FRA_OP_REDUCE_FILE) ||
             (cur_r.op == fra_pkg::FRA_OP_REDUCE_SKIP) ||
             (cur_r.op == fra_pkg::FRA_OP_RAISE_SKIP);
  end

  // read address follows the incoming operand while idle so data is ready in exec
  assign mif.addr = (cur_r.st == fra_pkg::FRA_ST_IDLE) ? file_addr_in : cur_r.addr;
  assign mif.waddr = cur_r.addr;
  assign mif.wdata = res;
  assign mif.we = (cur_r.st == fra_pkg::FRA_ST_EXEC) &&
                  ((cur_r.op == fra_pkg::FRA_OP_ZERO_FILE) ||
                   (routed && cur_r.dest == fra_pkg::FRA_DEST_FILE));

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.push = 1'b0;
    cur_nxt.skip = 1'b0;
    case (cur_r.st)
      fra_pkg::FRA_ST_IDLE: begin
        if (op_valid_in) begin
          cur_nxt.op = op_in;
          cur_nxt.addr = file_addr_in;
          cur_nxt.dest = dest_sel_in;
          cur_nxt.ready = 1'b0;
          cur_nxt.st = fra_pkg::FRA_ST_EXEC;
        end
      end
      fra_pkg::FRA_ST_EXEC: begin
        cur_nxt.pc = cur_r.pc + fra_pkg::FRA_PC_STEP;
        cur_nxt.ready = 1'b1;
        cur_nxt.st = fra_pkg::FRA_ST_IDLE;
        if (routed && cur_r.dest == fra_pkg::FRA_DEST_ACC) begin
          cur_nxt.acc = res;
        end
        case (cur_r.op)
          fra_pkg::FRA_OP_CALL_VIA_ACC: begin
            cur_nxt.stack_top = cur_r.pc + fra_pkg::FRA_PC_STEP;
            cur_nxt.push = 1'b1;
            cur_nxt.pc = {counter_high_latch_in, cur_r.acc};
            cur_nxt.ready = 1'b0;
            cur_nxt.st = fra_pkg::FRA_ST_NOP;
          end
          fra_pkg::FRA_OP_INVERT_FILE,
          fra_pkg::FRA_OP_REDUCE_FILE: begin
            cur_nxt.zf = res_zero;
          end
          fra_pkg::FRA_OP_ZERO_FILE: begin
            cur_nxt.zf = 1'b1;
          end
          fra_pkg::FRA_OP_ZERO_ACC: begin
            cur_nxt.acc = fra_pkg::FRA_ZERO_BYTE;
            cur_nxt.zf = 1'b1;
          end
          fra_pkg::FRA_OP_REDUCE_SKIP,
          fra_pkg::FRA_OP_RAISE_SKIP: begin
            // flags untouched; a zero result spends one more slot as a no-op
            if (res_zero) begin
              cur_nxt.skip = 1'b1;
              cur_nxt.pc = cur_r.pc + fra_pkg::FRA_PC_SKIP;
              cur_nxt.ready = 1'b0;
              cur_nxt.st = fra_pkg::FRA_ST_NOP;
            end
          end
          default: begin
            cur_nxt.st = fra_pkg::FRA_ST_IDLE;
          end
        endcase
      end
      fra_pkg::FRA_ST_NOP: begin
        cur_nxt.ready = 1'b1;
        cur_nxt.st = fra_pkg::FRA_ST_IDLE;
      end
      default: begin
        cur_nxt.st = fra_pkg::FRA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      cur_r.st <= fra_pkg::FRA_ST_IDLE;
      cur_r.op <= fra_pkg::FRA_OP_ZERO_ACC;
      cur_r.addr <= 7'h00;
      cur_r.dest <= fra_pkg::FRA_DEST_ACC;
      cur_r.ready <= 1'b1;
      cur_r.pc <= fra_pkg::FRA_PC_RST;
      cur_r.stack_top <= fra_pkg::FRA_TOS_RST;
      cur_r.push <= 1'b0;
      cur_r.skip <= 1'b0;
      cur_r.acc <= fra_pkg::FRA_ACC_RST;
      cur_r.zf <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign ready_out = cur_r.ready;
  assign program_counter_out = cur_r.pc;
  assign stack_top_out = cur_r.stack_top;
  assign push_out = cur_r.push;
  assign skip_out = cur_r.skip;
  assign accumulator_out = cur_r.acc;
  assign null_result_flag_out = cur_r.zf;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  logic take;
  assign take = ready_out && op_valid_in;

  sequence s_issue_call;
    take && op_in == fra_pkg::FRA_OP_CALL_VIA_ACC;
  endsequence

  sequence s_issue_keep;
    take && (op_in == fra_pkg::FRA_OP_CALL_VIA_ACC ||
             op_in == fra_pkg::FRA_OP_REDUCE_SKIP ||
             op_in == fra_pkg::FRA_OP_RAISE_SKIP);
  endsequence

  sequence s_issue_skip;
    take && (op_in == fra_pkg::FRA_OP_REDUCE_SKIP || op_in == fra_pkg::FRA_OP_RAISE_SKIP);
  endsequence

  sequence s_two_slots;
    !ready_out [*2] ##1 ready_out;
  endsequence

  chk_call_push_return: assert property (
    s_issue_call |-> ##2 (push_out && stack_top_out == $past(program_counter_out, 2) + 15'h0001))
    else $error("call did not push counter plus one");

  chk_call_target_addr: assert property (
    s_issue_call |-> ##2
      (program_counter_out == {$past(counter_high_latch_in, 1), $past(accumulator_out, 2)}))
    else $error("call target not latch and accumulator");

  chk_call_two_cycles: assert property (
    s_issue_call |-> ##1 s_two_slots)
    else $error("call did not take two slots");

  chk_flags_held_keep: assert property (
    s_issue_keep |-> ##2 (null_result_flag_out == $past(null_result_flag_out, 2)))
    else $error("flag changed on flag-preserving operation");

  chk_clear_sets_zero: assert property (
    take && (op_in == fra_pkg::FRA_OP_ZERO_FILE || op_in == fra_pkg::FRA_OP_ZERO_ACC)
      |-> ##2 null_result_flag_out)
    else $error("clear did not set zero flag");

  chk_clear_acc_value: assert property (
    take && op_in == fra_pkg::FRA_OP_ZERO_ACC |-> ##2 (accumulator_out == 8'h00 && ready_out))
    else $error("accumulator not cleared in one slot");

  chk_zero_flag_track: assert property (
    take && dest_sel_in == 1'b0 &&
      (op_in == fra_pkg::FRA_OP_INVERT_FILE || op_in == fra_pkg::FRA_OP_REDUCE_FILE)
      |-> ##2 (null_result_flag_out == (accumulator_out == 8'h00)))
    else $error("zero flag does not match result");

  chk_invert_to_acc: assert property (
    cur_r.st == fra_pkg::FRA_ST_EXEC && cur_r.op == fra_pkg::FRA_OP_INVERT_FILE && !cur_r.dest
      |=> accumulator_out == ~$past(mif.rdata))
    else $error("complement not routed to accumulator");

  chk_file_dest_acc: assert property (
    take && dest_sel_in == 1'b1 && op_in != fra_pkg::FRA_OP_ZERO_ACC
      |-> ##2 $stable(accumulator_out))
    else $error("file destination changed accumulator");

  chk_skip_counter_step: assert property (
    s_issue_skip |-> ##2
      (program_counter_out == $past(program_counter_out, 2) + (skip_out ? 15'h0002 : 15'h0001)))
    else $error("skip counter step wrong");

  chk_skip_on_zero: assert property (
    cur_r.st == fra_pkg::FRA_ST_EXEC &&
      (cur_r.op == fra_pkg::FRA_OP_REDUCE_SKIP || cur_r.op == fra_pkg::FRA_OP_RAISE_SKIP)
      |=> (skip_out == ($past(mif.wdata) == 8'h00)) and
          (if (skip_out) (!ready_out ##1 ready_out) else ready_out))
    else $error("skip not tied to zero result");
endmodule // fra_core
`default_nettype wire

// file: hdl/fra_pkg.sv
`default_nettype none
package fra_pkg;
  localparam int unsigned FRA_DATA_W = 8;
  localparam int unsigned FRA_ADDR_W = 7;
  localparam int unsigned FRA_PC_W = 15;
  localparam int unsigned FRA_HI_W = 7;
  localparam int unsigned FRA_FILE_DEPTH = 128;
  localparam logic [14:0] FRA_PC_RST = 15'h0000;
  localparam logic [14:0] FRA_TOS_RST = 15'h0000;
  localparam logic [7:0] FRA_ACC_RST = 8'h00;
  localparam logic [7:0] FRA_ZERO_BYTE = 8'h00;
  localparam logic [7:0] FRA_ONE_BYTE = 8'h01;
  localparam logic [14:0] FRA_PC_STEP = 15'h0001;
  localparam logic [14:0] FRA_PC_SKIP = 15'h0002;
  localparam logic FRA_DEST_ACC = 1'b0;
  localparam logic FRA_DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    FRA_OP_CALL_VIA_ACC,
    FRA_OP_INVERT_FILE,
    FRA_OP_ZERO_FILE,
    FRA_OP_ZERO_ACC,
    FRA_OP_REDUCE_FILE,
    FRA_OP_REDUCE_SKIP,
    FRA_OP_RAISE_SKIP
  } fra_op_t;

  typedef enum logic [1:0] {
    FRA_ST_IDLE,
    FRA_ST_EXEC,
    FRA_ST_NOP
  } fra_state_t;
endpackage
`default_nettype wire

// file: hdl/fra_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fra_mem_if;
  logic [6:0] addr;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport ctl (output addr, output waddr, output wdata, output we, input rdata);
  modport mem (input addr, input waddr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: hdl/fra_file_mem.sv
`timescale 1ns/100ps
`default_nettype none
module fra_file_mem (
  input wire logic mclk_in,
  fra_mem_if.mem mif
);
  // no reset on the array: contents are undefined until written
  logic [7:0] mem_r [fra_pkg::FRA_FILE_DEPTH];
  logic [7:0] rdata_r;

  always_ff @(posedge mclk_in) begin
    if (mif.we) begin
      mem_r[mif.waddr] <= mif.wdata;
    end
    rdata_r <= mem_r[mif.addr];
  end

  assign mif.rdata = rdata_r;
endmodule // fra_file_mem
`default_nettype wire

// file: sim/fra_core_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module fra_core_test;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic op_valid_in = 1'b0;
  fra_pkg::fra_op_t op_in = fra_pkg::FRA_OP_ZERO_ACC;
  logic [6:0] file_addr_in = 7'h00;
  logic dest_sel_in = 1'b0;
  logic [6:0] counter_high_latch_in = 7'h00;
  logic ready_out;
  logic [14:0] program_counter_out;
  logic [14:0] stack_top_out;
  logic push_out;
  logic skip_out;
  logic [7:0] accumulator_out;
  logic null_result_flag_out;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'h776238c1;
  // file contents survive reset, so this shadow is never cleared
  logic [7:0] mem_m [128];
  logic [7:0] acc_m;
  logic [14:0] prog_m;
  logic [14:0] top_m;
  logic flag_m;

  fra_core i_dut (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .op_valid_in(op_valid_in),
    .op_in(op_in),
    .file_addr_in(file_addr_in),
    .dest_sel_in(dest_sel_in),
    .counter_high_latch_in(counter_high_latch_in),
    .ready_out(ready_out),
    .program_counter_out(program_counter_out),
    .stack_top_out(stack_top_out),
    .push_out(push_out),
    .skip_out(skip_out),
    .accumulator_out(accumulator_out),
    .null_result_flag_out(null_result_flag_out)
  );

  always #25 mclk_in = ~mclk_in;

  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hang is cut off at 20000 cycles, far beyond the roughly 1400 cycles of traffic
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] alu_res(input fra_pkg::fra_op_t op, input logic [7:0] v);
    case (op)
      fra_pkg::FRA_OP_INVERT_FILE: return ~v;
      fra_pkg::FRA_OP_RAISE_SKIP: return v + 8'h01;
      default: return v - 8'h01;
    endcase
  endfunction

  task automatic do_reset();
    rstn_in = 1'b0;
    op_valid_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    prog_m = fra_pkg::FRA_PC_RST;
    top_m = fra_pkg::FRA_TOS_RST;
    acc_m = fra_pkg::FRA_ACC_RST;
    flag_m = 1'b0;
    `CHK("ready", 1'b1, ready_out)
    `CHK("push", 1'b0, push_out)
    `CHK("skip", 1'b0, skip_out)
    rstn_in = 1'b1;
  endtask

  task automatic do_op(input fra_pkg::fra_op_t op, input logic [6:0] a, input logic d,
      input logic [6:0] hi);
    logic [7:0] r;
    logic skp;
    logic sk_op;
    int k;
    r = alu_res(op, mem_m[a]);
    sk_op = op inside {fra_pkg::FRA_OP_REDUCE_SKIP, fra_pkg::FRA_OP_RAISE_SKIP};
    skp = sk_op && (r == 8'h00);
    for (k = 0; k < 8 && ready_out !== 1'b1; k++) @(negedge mclk_in);
    op_valid_in = 1'b1;
    op_in = op;
    file_addr_in = a;
    dest_sel_in = d;
    counter_high_latch_in = hi;
    @(posedge mclk_in);
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    // results settle one edge after the take; pulses stand for that one cycle only
    @(negedge mclk_in);
    case (op)
      fra_pkg::FRA_OP_CALL_VIA_ACC: begin
        top_m = prog_m + 15'h0001;
        prog_m = {hi, acc_m};
      end
      fra_pkg::FRA_OP_ZERO_FILE: begin
        mem_m[a] = 8'h00;
        flag_m = 1'b1;
      end
      fra_pkg::FRA_OP_ZERO_ACC: begin
        acc_m = 8'h00;
        flag_m = 1'b1;
      end
      default: begin
        if (d) mem_m[a] = r;
        else acc_m = r;
        if (!sk_op) flag_m = (r == 8'h00);
      end
    endcase
    if (op != fra_pkg::FRA_OP_CALL_VIA_ACC) prog_m = prog_m + (skp ? 15'h0002 : 15'h0001);
    `CHK("program_counter", prog_m, program_counter_out)
    `CHK("stack_top", top_m, stack_top_out)
    `CHK("push", op == fra_pkg::FRA_OP_CALL_VIA_ACC, push_out)
    `CHK("skip", skp, skip_out)
    `CHK("acc", acc_m, accumulator_out)
    `CHK("zero", flag_m, null_result_flag_out)
    `CHK("ready", !(op == fra_pkg::FRA_OP_CALL_VIA_ACC || skp), ready_out)
  endtask

  initial begin
    do_reset();
    for (int a = 0; a < 128; a++) do_op(fra_pkg::FRA_OP_ZERO_FILE, 7'(a), 1'b1, 7'h00);
    do_op(fra_pkg::FRA_OP_RAISE_SKIP, 7'h7f, 1'b1, 7'h00);
    do_op(fra_pkg::FRA_OP_REDUCE_SKIP, 7'h7f, 1'b1, 7'h00);
    do_op(fra_pkg::FRA_OP_INVERT_FILE, 7'h7f, 1'b0, 7'h00);
    do_op(fra_pkg::FRA_OP_CALL_VIA_ACC, 7'h00, 1'b0, 7'h7f);
    do_op(fra_pkg::FRA_OP_INVERT_FILE, 7'h7f, 1'b1, 7'h00);
    do_op(fra_pkg::FRA_OP_RAISE_SKIP, 7'h7f, 1'b0, 7'h00);
    do_op(fra_pkg::FRA_OP_CALL_VIA_ACC, 7'h00, 1'b0, 7'h00);
    do_op(fra_pkg::FRA_OP_REDUCE_FILE, 7'h00, 1'b1, 7'h00);
    do_op(fra_pkg::FRA_OP_ZERO_ACC, 7'h00, 1'b0, 7'h00);
    // small address pool half the time, so values drift away from 00h and ffh
    for (int i = 0; i < 400; i++) begin
      rnd = lfsr_next(rnd);
      do_op(fra_pkg::fra_op_t'(rnd[2:0] % 3'h7), rnd[10] ? rnd[9:3] : {4'h0, rnd[5:3]},
        rnd[11], rnd[18:12]);
      if (i == 200) do_reset();
    end
    for (int a = 0; a < 128; a++)
      do_op(fra_pkg::FRA_OP_INVERT_FILE, 7'(a), 1'b0, 7'h00);
    test_done();
  end
endmodule // fra_core_test
`default_nettype wire
